// ==== rtl/vlan_pkg.sv ====
// shared constants and types for the vlan tag classifier
package vlan_pkg;
  localparam int NPORTS = 8;
  localparam int PW = 3;
  localparam int VID_W = 12;
  localparam int MEM_W = NPORTS + 1;
  localparam logic [VID_W-1:0] VID_NULL = 12'h000;
  localparam logic [VID_W-1:0] VID_FALLBACK = 12'h001;
  localparam logic [VID_W-1:0] VID_MAX = 12'hFFF;
  localparam logic [7:0] MAX_VLANS = 8'hFF;
  localparam logic [7:0] TPID_HI = 8'h81;
  localparam logic [7:0] TPID_LO = 8'h00;
  // delay line stages (byte k of a frame sits at stage 15-k when its sof is at stage 15)
  localparam int DEPTH = 23;
  localparam int CLS_STG = 15;
  localparam int DEC_STG = 17;
  localparam int ET_HI_STG = 3;
  localparam int ET_LO_STG = 2;
  localparam int TCI_HI_STG = 1;
  localparam int TCI_LO_STG = 0;
  localparam logic [4:0] TAP_BASE = 5'h12;
  localparam logic [4:0] TAP_INS = 5'h16;
  localparam logic [4:0] TAP_STRIP = 5'h0E;
  localparam logic [4:0] FCS_SPAN = 5'h03;
  localparam logic [3:0] SA_LAST = 4'hB;
  localparam logic [1:0] LAST_OF_FOUR = 2'h3;
  localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
  localparam logic [31:0] CRC_POLY = 32'hEDB88320;
  // register map
  localparam logic [11:0] A_CTRL = 12'h000;
  localparam logic [11:0] A_SEL = 12'h004;
  localparam logic [11:0] A_MEMB = 12'h008;
  localparam logic [11:0] A_DROP = 12'h00C;
  localparam logic [6:0] PORT_PAGE = 7'h01;
  localparam int MEMB_VALID_BIT = 31;
  localparam int PORT_TAG_BIT = 16;
  localparam int CTRL_BUSY_BIT = 8;
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_PASS = 3'b001,
    S_TAG = 3'b010,
    S_FCS = 3'b011,
    S_DROP = 3'b100
  } out_state_t;
endpackage

// ==== rtl/vlan_mem.sv ====
// membership table indexed by vid, one write port and two registered read ports
`timescale 1ns/1ps
module vlan_mem import vlan_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic we,
  input wire logic [VID_W-1:0] waddr,
  input wire logic [MEM_W-1:0] wdata,
  input wire logic [VID_W-1:0] raddr_a,
  output logic [MEM_W-1:0] rdata_a,
  input wire logic [VID_W-1:0] raddr_b,
  output logic [MEM_W-1:0] rdata_b
);
  logic [MEM_W-1:0] mem [2**VID_W];

  always_ff @(posedge pclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_a <= '0;
      rdata_b <= '0;
    end else begin
      rdata_a <= mem[raddr_a];
      rdata_b <= mem[raddr_b];
    end
  end
endmodule // vlan_mem

// ==== rtl/crc32_byte.sv ====
// running ethernet crc over a byte stream
`timescale 1ns/1ps
module crc32_byte import vlan_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic init,
  input wire logic en,
  input wire logic [7:0] data,
  output logic [31:0] crc
);
  function automatic logic [31:0] step(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c ^ {24'h000000, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crc <= CRC_INIT;
    end else if (init) begin
      // the first byte of a frame arrives in the same cycle as the restart
      crc <= en ? step(CRC_INIT, data) : CRC_INIT;
    end else if (en) begin
      crc <= step(crc, data);
    end
  end
endmodule // crc32_byte

// ==== rtl/vlan_tag_classifier.sv ====
// vlan classification, egress filtering and tag editing with apb configuration
//
// Overview of operation
// - a frame is tagged when its type field after the source address is 0x8100
// - tag control splits into 3-bit priority, 1-bit format bit, 12-bit vid
// - inserted tag goes after source address; all original bytes but the fcs kept, frame grows 4
// - any frame whose tag was added or removed gets a freshly computed fcs
// - untagged frames take the default vid of their ingress port
// - tagged frames use their own vid unless it is 0; then the port default applies
// - frames whose vid is not assigned to the egress port are discarded
// - each port has one default vid and may join many vlans
// - after reset only vid 1 exists, all ports untagged members, default vid 1
// - defining a new vlan removes its members from fallback vlan 1
// - up to 255 vlans may be defined at once
// - flooded frames reach only members of the classified vlan
// - per-port egress tagging setting; untagged ports strip the tag
// - a port may be member of several vlans at once
// - tagged egress keeps an existing tag and tags untagged frames
// - untagged egress forwards untagged frames unchanged
//
// Design decisions made here: the register offsets and the APB register port.
`timescale 1ns/1ps
module vlan_tag_classifier import vlan_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic in_valid,
  input wire logic [7:0] in_data,
  input wire logic in_sof,
  input wire logic in_eof,
  input wire logic [PW-1:0] in_port,
  input wire logic [PW-1:0] in_egress_port,
  output logic out_valid,
  output logic [7:0] out_data,
  output logic out_sof,
  output logic out_eof,
  output logic [PW-1:0] out_port,
  output logic [VID_W-1:0] out_vid,
  output logic [2:0] out_pcp,
  output logic out_canonical_format_bit
);
  // delay line: frames flow through at a fixed rate, edits only move the read tap
  logic [7:0] sd [DEPTH];
  logic [DEPTH-1:0] sv, ss, se;
  logic [PW-1:0] hd_port, hd_eg;
  logic [VID_W-1:0] c_vid, d_vid, o_vid;
  logic [PW-1:0] c_eg, d_eg, o_eg;
  logic [2:0] c_pcp, d_pcp, o_pcp;
  logic c_cfi, d_cfi, o_cfi, c_tag;
  logic d_drop, d_ins, d_strip, o_ins, o_strip;
  logic [VID_W-1:0] pvid [NPORTS];
  logic [NPORTS-1:0] port_tagged, fallback_vlan_group;
  logic [VID_W-1:0] sel;
  logic [7:0] count;
  logic [31:0] drops;
  logic busy;
  logic [VID_W-1:0] init_cnt;
  logic [MEM_W-1:0] ra, rb;
  out_state_t st, next_st;
  logic [4:0] tap, next_tap;
  logic [3:0] oc, next_oc;
  logic [1:0] ti, next_ti;
  logic [31:0] crc, fcs_w;
  logic emit, emit_sof, emit_eof, crc_en, fcs_start;
  logic [7:0] emit_d;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sv <= '0;
      ss <= '0;
      se <= '0;
    end else begin
      sv <= {sv[DEPTH-2:0], in_valid};
      ss <= {ss[DEPTH-2:0], in_valid & in_sof};
      se <= {se[DEPTH-2:0], in_valid & in_eof};
    end
  end

  always_ff @(posedge pclk) begin
    sd[0] <= in_data;
    for (int i = 1; i < DEPTH; i++) begin
      sd[i] <= sd[i-1];
    end
  end

  // ingress classification when the frame start reaches the tag-control bytes
  wire cls_hit = sv[CLS_STG] & ss[CLS_STG];
  wire is_tag = (sd[ET_HI_STG] == TPID_HI) && (sd[ET_LO_STG] == TPID_LO);
  wire [VID_W-1:0] tag_vid = {sd[TCI_HI_STG][3:0], sd[TCI_LO_STG]};
  // a priority-only tag (vid 0) still falls back to the port default
  wire use_tag = is_tag && (tag_vid != VID_NULL);
  wire [VID_W-1:0] cls_vid = use_tag ? tag_vid : pvid[hd_port];

  // egress decision two cycles later, once the table lookup has returned
  wire dec_hit = sv[DEC_STG] & ss[DEC_STG];
  wire member = (c_vid == VID_FALLBACK) ? fallback_vlan_group[c_eg] : (ra[NPORTS] & ra[c_eg]);
  wire eg_tagged = port_tagged[c_eg];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hd_port <= '0;
      hd_eg <= '0;
      c_vid <= VID_FALLBACK;
      c_eg <= '0;
      c_pcp <= '0;
      c_cfi <= 1'b0;
      c_tag <= 1'b0;
      d_vid <= VID_FALLBACK;
      d_eg <= '0;
      d_pcp <= '0;
      d_cfi <= 1'b0;
      d_drop <= 1'b1;
      d_ins <= 1'b0;
      d_strip <= 1'b0;
    end else begin
      if (in_valid & in_sof) begin
        hd_port <= in_port;
        hd_eg <= in_egress_port;
      end
      if (cls_hit) begin
        c_vid <= cls_vid;
        c_eg <= hd_eg;
        c_tag <= is_tag;
        c_pcp <= is_tag ? sd[TCI_HI_STG][7:5] : 3'h0;
        c_cfi <= is_tag & sd[TCI_HI_STG][4];
      end
      if (dec_hit) begin
        d_vid <= c_vid;
        d_eg <= c_eg;
        d_pcp <= c_pcp;
        d_cfi <= c_cfi;
        d_drop <= ~member;
        d_ins <= ~c_tag & eg_tagged;
        d_strip <= c_tag & ~eg_tagged;
      end
    end
  end

  // output editor
  wire [7:0] tap_d = sd[tap];
  wire tap_v = sv[tap];
  wire tap_e = se[tap];
  wire [DEPTH-1:0] e_win = se >> (tap - FCS_SPAN);
  wire fcs_now = |e_win[3:0];
  wire modified = o_ins | o_strip;
  // attributes load with the first byte so they never lag the frame
  wire start = (st == S_IDLE) & sv[TAP_BASE] & ss[TAP_BASE];
  wire [7:0] tag_b2 = {3'h0, 1'b0, o_vid[11:8]};
  wire [7:0] tag_byte = (ti == 2'h0) ? TPID_HI : (ti == 2'h1) ? TPID_LO : (ti == 2'h2) ? tag_b2 : o_vid[7:0];

  always_comb begin
    next_st = st;
    next_tap = tap;
    next_oc = oc;
    next_ti = ti;
    emit = 1'b0;
    emit_d = tap_d;
    emit_sof = 1'b0;
    emit_eof = 1'b0;
    crc_en = 1'b0;
    fcs_start = 1'b0;
    unique case (st)
      S_IDLE: begin
        if (sv[TAP_BASE] & ss[TAP_BASE]) begin
          next_tap = TAP_BASE;
          next_oc = 4'h1;
          if (d_drop) begin
            next_st = S_DROP;
          end else begin
            emit = 1'b1;
            emit_sof = 1'b1;
            crc_en = 1'b1;
            next_st = S_PASS;
          end
        end
      end
      S_PASS: begin
        if (modified && fcs_now) begin
          // original fcs is replaced by one over the edited frame
          emit = 1'b1;
          emit_d = ~crc[7:0];
          fcs_start = 1'b1;
          next_ti = 2'h1;
          next_st = S_FCS;
        end else begin
          emit = tap_v;
          crc_en = tap_v;
          emit_eof = tap_e;
          if (oc <= SA_LAST) begin
            next_oc = oc + 4'h1;
          end
          if (tap_e) begin
            next_st = S_IDLE;
          end else if (oc == SA_LAST && o_ins) begin
            next_ti = 2'h0;
            next_st = S_TAG;
          end else if (oc == SA_LAST && o_strip) begin
            next_tap = TAP_STRIP;
          end
        end
      end
      S_TAG: begin
        emit = 1'b1;
        emit_d = tag_byte;
        crc_en = 1'b1;
        next_ti = ti + 2'h1;
        if (ti == LAST_OF_FOUR) begin
          next_tap = TAP_INS;
          next_st = S_PASS;
        end
      end
      S_FCS: begin
        emit = 1'b1;
        emit_d = fcs_w[{ti, 3'b000} +: 8];
        next_ti = ti + 2'h1;
        if (ti == LAST_OF_FOUR) begin
          emit_eof = 1'b1;
          // an edited frame leaves the tap moved; the next start reads the base stage
          next_tap = TAP_BASE;
          next_st = S_IDLE;
        end
      end
      S_DROP: begin
        if (tap_v & tap_e) begin
          next_st = S_IDLE;
        end
      end
      default: begin
        next_st = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= S_IDLE;
      tap <= TAP_BASE;
      oc <= '0;
      ti <= '0;
      fcs_w <= '0;
      o_vid <= VID_FALLBACK;
      o_eg <= '0;
      o_pcp <= '0;
      o_cfi <= 1'b0;
      o_ins <= 1'b0;
      o_strip <= 1'b0;
      drops <= '0;
    end else begin
      st <= next_st;
      tap <= next_tap;
      oc <= next_oc;
      ti <= next_ti;
      if (fcs_start) begin
        fcs_w <= ~crc;
      end
      if (start) begin
        o_vid <= d_vid;
        o_eg <= d_eg;
        o_pcp <= d_pcp;
        o_cfi <= d_cfi;
        o_ins <= d_ins;
        o_strip <= d_strip;
        if (d_drop) begin
          drops <= drops + 32'h1;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_valid <= 1'b0;
      out_data <= '0;
      out_sof <= 1'b0;
      out_eof <= 1'b0;
      out_port <= '0;
      out_vid <= VID_FALLBACK;
      out_pcp <= '0;
      out_canonical_format_bit <= 1'b0;
    end else begin
      out_valid <= emit;
      out_data <= emit_d;
      out_sof <= emit_sof;
      out_eof <= emit_eof;
      out_port <= start ? d_eg : o_eg;
      out_vid <= start ? d_vid : o_vid;
      out_pcp <= start ? d_pcp : o_pcp;
      out_canonical_format_bit <= start ? d_cfi : o_cfi;
    end
  end

  crc32_byte u_crc (
    .pclk(pclk),
    .presetn(presetn),
    .init(st == S_IDLE),
    .en(crc_en),
    .data(emit_d),
    .crc(crc)
  );

  // apb slave: one wait state, writes land on the completing edge
  wire acc = psel & penable;
  wire done = acc & pready;
  wire a_ctrl = paddr == A_CTRL;
  wire a_sel = paddr == A_SEL;
  wire a_memb = paddr == A_MEMB;
  wire a_drop = paddr == A_DROP;
  wire a_port = (paddr[11:5] == PORT_PAGE) && (paddr[1:0] == 2'b00);
  wire [PW-1:0] pidx = paddr[PW+1:2];
  wire sel_fb = sel == VID_FALLBACK;
  wire sel_bad = (sel == VID_NULL) || (sel == VID_MAX);
  wire new_valid = pwdata[MEMB_VALID_BIT];
  wire old_valid = rb[NPORTS];
  wire full_err = new_valid & ~old_valid & (count == MAX_VLANS);
  wire memb_err = pwrite & a_memb & ~sel_fb & (sel_bad | full_err);
  wire err = ~(a_ctrl | a_sel | a_memb | a_drop | a_port) | memb_err;
  wire wr_memb = done & pwrite & ~pslverr & a_memb;
  wire mem_we = busy | (wr_memb & ~sel_fb);
  wire [MEM_W-1:0] mem_wd = busy ? '0 : {new_valid, pwdata[NPORTS-1:0]};
  wire [MEM_W-1:0] memb_rd = sel_fb ? {1'b1, fallback_vlan_group} : rb;
  wire [31:0] port_rd = 32'(pvid[pidx]) | (32'(port_tagged[pidx]) << PORT_TAG_BIT);
  wire [31:0] rd_val = a_ctrl ? (32'(count) | (32'(busy) << CTRL_BUSY_BIT)) :
                       a_sel ? 32'(sel) :
                       a_memb ? ((32'(memb_rd[MEM_W-1]) << MEMB_VALID_BIT) | 32'(memb_rd[NPORTS-1:0])) :
                       a_drop ? drops :
                       a_port ? port_rd : 32'h00000000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      // held off while the table is being cleared after reset
      pready <= acc & ~pready & ~busy;
      pslverr <= acc & ~pready & ~busy & err;
      if (acc & ~pready) begin
        prdata <= rd_val;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy <= 1'b1;
      init_cnt <= '0;
      sel <= VID_FALLBACK;
      count <= 8'h01;
      fallback_vlan_group <= '1;
      port_tagged <= '0;
      for (int p = 0; p < NPORTS; p++) begin
        pvid[p] <= VID_FALLBACK;
      end
    end else begin
      if (busy) begin
        init_cnt <= init_cnt + 12'h001;
        busy <= init_cnt != VID_MAX;
      end
      if (done & pwrite & ~pslverr & a_sel) begin
        sel <= pwdata[VID_W-1:0];
      end
      if (done & pwrite & ~pslverr & a_port) begin
        pvid[pidx] <= pwdata[VID_W-1:0];
        port_tagged[pidx] <= pwdata[PORT_TAG_BIT];
      end
      if (wr_memb & sel_fb) begin
        fallback_vlan_group <= pwdata[NPORTS-1:0];
      end else if (wr_memb & new_valid) begin
        fallback_vlan_group <= fallback_vlan_group & ~pwdata[NPORTS-1:0];
      end
      if (wr_memb & ~sel_fb & new_valid & ~old_valid) begin
        count <= count + 8'h01;
      end else if (wr_memb & ~sel_fb & ~new_valid & old_valid) begin
        count <= count - 8'h01;
      end
    end
  end

  vlan_mem u_mem (
    .pclk(pclk),
    .presetn(presetn),
    .we(mem_we),
    .waddr(busy ? init_cnt : sel),
    .wdata(mem_wd),
    .raddr_a(c_vid),
    .rdata_a(ra),
    .raddr_b(sel),
    .rdata_b(rb)
  );
endmodule // vlan_tag_classifier

// ==== test/vlan_tag_classifier_asserts.sv ====
// port level checks for the vlan tag classifier
`timescale 1ns/1ps
module vlan_tag_classifier_asserts import vlan_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic in_valid,
  input wire logic in_sof,
  input wire logic out_valid,
  input wire logic [7:0] out_data,
  input wire logic out_sof,
  input wire logic out_eof,
  input wire logic [VID_W-1:0] out_vid,
  input wire logic [2:0] out_pcp,
  input wire logic out_canonical_format_bit
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ready_in_access_a: assert property (pready |-> psel && penable && $past(penable))
    else $error("pready outside second access cycle");
  ready_one_cycle_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  error_with_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  sof_latency_a: assert property (out_sof |-> $past(in_valid && in_sof, 20))
    else $error("out_sof not 20 cycles after in_sof");
  marks_in_frame_a: assert property ((out_sof || out_eof) |-> out_valid)
    else $error("frame mark without valid");
  frame_contiguous_a: assert property (out_valid && !out_eof |=> out_valid)
    else $error("gap inside output frame");
  gap_after_eof_a: assert property (out_eof |=> !out_valid)
    else $error("byte right after out_eof");
  attrs_stable_a: assert property (out_valid && !out_sof |-> $stable(out_vid) && $stable(out_pcp))
    else $error("frame attributes moved in frame");
  tag_bytes_a: assert property (out_sof ##12 (out_data == TPID_HI) ##1 (out_data == TPID_LO)
    |=> (out_data == {out_pcp, out_canonical_format_bit, out_vid[11:8]}) ##1 (out_data == out_vid[7:0]))
    else $error("tag control bytes disagree with attributes");
endmodule // vlan_tag_classifier_asserts

// ==== test/port_mac_model.sv ====
// frame source standing in for the port macs and forwarding engine
`timescale 1ns/1ps
module port_mac_model import vlan_pkg::*; (
  input wire logic pclk,
  output logic in_valid,
  output logic [7:0] in_data,
  output logic in_sof,
  output logic in_eof,
  output logic [PW-1:0] in_port,
  output logic [PW-1:0] in_egress_port
);
  initial begin
    in_valid = 1'b0;
    in_data = 8'h00;
    in_sof = 1'b0;
    in_eof = 1'b0;
    in_port = 3'h0;
    in_egress_port = 3'h0;
  end
  // bytes go back to back: the block has no back-pressure
  task automatic send(input logic [7:0] f[$], input logic [PW-1:0] p, input logic [PW-1:0] e);
    for (int i = 0; i < f.size(); i++) begin
      @(posedge pclk);
      in_valid <= 1'b1;
      in_data <= f[i];
      in_sof <= (i == 0);
      in_eof <= (i == f.size() - 1);
      in_port <= p;
      in_egress_port <= e;
    end
    @(posedge pclk);
    in_valid <= 1'b0;
    in_sof <= 1'b0;
    in_eof <= 1'b0;
    // idle lines never repeat the last byte, so stale data cannot pass
    in_data <= ~f[f.size()-1];
    in_port <= ~p;
  endtask
endmodule // port_mac_model

// ==== test/vlan_tag_classifier_tb.sv ====
// self-checking bench for the vlan tag classifier with a queue based model
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin \
  compares++; \
  if ((gt) !== (ex)) begin \
    n_fail++; \
    $display("unexpected %s exp %0h got %0h", nm, ex, gt); \
  end \
end
module vlan_tag_classifier_tb import vlan_pkg::*; ();
  typedef logic [7:0] bq_t[$];
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic in_valid, in_sof, in_eof, out_valid, out_sof, out_eof, out_canonical_format_bit;
  logic [7:0] in_data, out_data;
  logic [PW-1:0] in_port, in_egress_port, out_port;
  logic [VID_W-1:0] out_vid, got_vid;
  logic [2:0] out_pcp, got_pcp;
  logic [PW-1:0] got_port;
  logic got_fmt;
  int n_fail, compares, cycles, drops, eof_at;
  int pvid[8], mem[int];
  bit tg[8];
  bq_t got;
  int tp[9] = '{0, 0, 1, 1, 4, 4, 3, 3, 4};
  int te[9] = '{2, 4, 2, 1, 2, 1, 1, 4, 1};
  int tt[9] = '{0, 0, 0, 0, 10, 10, 0, 0, 20};
  int vids[5] = '{0, 1, 10, 20, 30};

  vlan_tag_classifier i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .in_valid, .in_data, .in_sof, .in_eof, .in_port, .in_egress_port, .out_valid, .out_data,
    .out_sof, .out_eof, .out_port, .out_vid, .out_pcp, .out_canonical_format_bit);
  port_mac_model i_mac (.pclk, .in_valid, .in_data, .in_sof, .in_eof, .in_port, .in_egress_port);

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  task print_verdict();
    if (n_fail == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      print_verdict();
    end
  end

  always @(posedge pclk) begin
    if (out_valid === 1'b1) begin
      got.push_back(out_data);
      if (out_sof === 1'b1) begin
        got_vid = out_vid;
        got_pcp = out_pcp;
        got_port = out_port;
        got_fmt = out_canonical_format_bit;
      end
      if (out_eof === 1'b1) begin
        eof_at = got.size();
      end
    end
  end

  // reflected crc, sent low byte first
  function automatic void add_fcs(ref bq_t q);
    logic [31:0] c;
    c = CRC_INIT;
    foreach (q[i]) begin
      c = c ^ {24'h0, q[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
    end
    c = ~c;
    for (int k = 0; k < 4; k++) q.push_back(c[8*k+:8]);
  endfunction

  function automatic bq_t model(input bq_t f, input int p, input int e, output int vid,
      output logic [2:0] pc, output bit keep);
    bq_t o;
    bit ti;
    o = f;
    ti = f[12] === TPID_HI && f[13] === TPID_LO;
    vid = ti ? {f[14][3:0], f[15]} : pvid[p];
    pc = ti ? f[14][7:5] : 3'h0;
    keep = mem.exists(vid) && mem[vid][e];
    if (ti != tg[e]) begin
      o = o[0:$-4];
      if (ti) repeat (4) o.delete(12);
      else begin
        o.insert(12, 8'(vid));
        o.insert(12, {4'h0, 4'(vid >> 8)});
        o.insert(12, TPID_LO);
        o.insert(12, TPID_HI);
      end
      add_fcs(o);
    end
    return o;
  endfunction

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] ex,
      input logic er);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    `CHK("pslverr", er, pslverr)
    if (!w) `CHK("prdata", ex, prdata)
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic run(input int p, input int e, input int tv);
    bq_t f, x;
    int vid;
    logic [2:0] pc;
    bit keep;
    bit fm;
    f = {};
    repeat (60 + $urandom_range(30)) f.push_back(8'($urandom));
    f[12] = 8'h08;
    f[13] = 8'h00;
    if (tv > 0) begin
      f[12] = TPID_HI;
      f[13] = TPID_LO;
      f[14] = {4'($urandom), 4'(tv >> 8)};
      f[15] = 8'(tv);
    end
    add_fcs(f);
    fm = (tv > 0) && f[14][4];
    x = model(f, p, e, vid, pc, keep);
    got = {};
    eof_at = 0;
    i_mac.send(f, 3'(p), 3'(e));
    repeat (30) @(posedge pclk);
    if (!keep) begin
      x = {};
      drops++;
    end
    `CHK("length", x.size(), got.size())
    if (x.size() == got.size()) foreach (x[i]) `CHK("byte", x[i], got[i])
    if (keep) `CHK("vid", 12'(vid), got_vid)
    if (keep) `CHK("pcp", pc, got_pcp)
    if (keep) `CHK("format bit", fm, got_fmt)
    if (keep) `CHK("port", 3'(e), got_port)
    `CHK("eof position", x.size(), eof_at)
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    foreach (pvid[i]) pvid[i] = 1;
    mem[1] = 32'hFF;
    void'($urandom(31799));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, A_CTRL, 32'h0, 32'h1, 1'b0);
    apb(1'b0, A_MEMB, 32'h0, 32'h800000FF, 1'b0);
    apb(1'b0, 12'h024, 32'h0, 32'h1, 1'b0);
    apb(1'b0, 12'h010, 32'h0, 32'h0, 1'b1);
    run(0, 5, 0);
    apb(1'b1, A_SEL, 32'hA, 32'h0, 1'b0);
    apb(1'b1, A_MEMB, 32'h80000006, 32'h0, 1'b0);
    apb(1'b1, A_SEL, 32'h14, 32'h0, 1'b0);
    apb(1'b1, A_MEMB, 32'h8000000A, 32'h0, 1'b0);
    apb(1'b1, 12'h024, 32'h1000A, 32'h0, 1'b0);
    apb(1'b1, 12'h02C, 32'h14, 32'h0, 1'b0);
    mem[10] = 32'h06;
    mem[20] = 32'h0A;
    mem[1] = 32'hF1;
    pvid[1] = 10;
    tg[1] = 1'b1;
    pvid[3] = 20;
    apb(1'b1, A_SEL, 32'h1, 32'h0, 1'b0);
    apb(1'b0, A_MEMB, 32'h0, 32'h800000F1, 1'b0);
    apb(1'b0, A_CTRL, 32'h0, 32'h3, 1'b0);
    apb(1'b1, A_SEL, 32'h0, 32'h0, 1'b0);
    apb(1'b1, A_MEMB, 32'h80000001, 32'h0, 1'b1);
    // fill the table up to its limit with empty vlans, then one more is refused
    for (int v = 100; v < 352; v++) begin
      apb(1'b1, A_SEL, 32'(v), 32'h0, 1'b0);
      apb(1'b1, A_MEMB, 32'h80000000, 32'h0, 1'b0);
    end
    apb(1'b1, A_SEL, 32'h160, 32'h0, 1'b0);
    apb(1'b1, A_MEMB, 32'h80000000, 32'h0, 1'b1);
    apb(1'b0, A_CTRL, 32'h0, 32'hFF, 1'b0);
    for (int i = 0; i < 9; i++) run(tp[i], te[i], tt[i]);
    repeat (16) run($urandom_range(7), $urandom_range(7), vids[$urandom_range(4)]);
    apb(1'b0, A_DROP, 32'h0, 32'(drops), 1'b0);
    print_verdict();
  end
endmodule // vlan_tag_classifier_tb

bind vlan_tag_classifier vlan_tag_classifier_asserts i_chk (.pclk, .presetn, .psel, .penable, .pready, .pslverr,
  .in_valid, .in_sof, .out_valid, .out_data, .out_sof, .out_eof, .out_vid, .out_pcp, .out_canonical_format_bit);
